// ---- rtl/acc_conv_ctrl.sv ----
// converter control top: start, track/hold, power-down, over-temperature alert, serial port
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_conv_ctrl
(
  // clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  // serial link pins
  input  wire logic                sclk_in,
  input  wire logic                cs_n_in,
  input  wire logic                rd_wr_in,
  input  wire logic                sdata_in,
  output logic                     sdata_out,
  output logic                     sdata_oe_out,
  // conversion control
  input  wire logic                conversion_start_n_in,
  input  wire acc_pkg::acc_result_t adc_data_in,
  output acc_pkg::acc_chan_t       analog_inputs_sel_out,
  output logic                     hold_out,
  output logic                     busy_out,
  output logic                     power_down_out,
  output logic                     overtemp_alert_n_out
);
  import acc_pkg::*;

  // three-flop filter: a change counts once stages two and three agree
  function automatic logic [`ACC_SYNC_W-1:0] settle
  (
    input logic [`ACC_SYNC_W-1:0] s2,
    input logic [`ACC_SYNC_W-1:0] s3,
    input logic [`ACC_SYNC_W-1:0] prev
  );
    settle = (s2 & s3) | (prev & (s2 ^ s3));
  endfunction : settle

  acc_link_if link ();

  logic [`ACC_SYNC_W-1:0]   sync1;
  logic [`ACC_SYNC_W-1:0]   sync2;
  logic [`ACC_SYNC_W-1:0]   sync3;
  logic [`ACC_SYNC_W-1:0]   filt;
  logic [`ACC_SYNC_W-1:0]   next_filt;
  acc_state_t               state;
  logic [`ACC_CONV_CNT_W-1:0] conv_cnt;
  acc_chan_t                conv_chan;
  acc_result_t              latest_result;
  acc_result_t              result_word;
  acc_byte_t                overtemp_threshold_reg;

  wire start_fall;
  wire start_rise;
  wire read_active;
  wire read_end;
  wire wr_event;
  wire wr_is_addr;
  wire conv_done;
  wire temp_over;
  wire temp_done;

  acc_serial u_serial
  (
    .sclk_in    (sclk_in),
    .reset_n_in (reset_n_in),
    .cs_n_in    (cs_n_in),
    .rd_wr_in   (rd_wr_in),
    .sdata_in   (sdata_in),
    .link       (link.ser)
  );

  // pins and the write toggle come from outside this clock
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      // start and select idle high, so no false edge follows reset
      sync1 <= 4'h3;
      sync2 <= 4'h3;
      sync3 <= 4'h3;
      filt  <= 4'h3;
    end
    else
    begin
      sync1 <= {link.wr_toggle, rd_wr_in, cs_n_in, conversion_start_n_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  assign next_filt   = settle(sync2, sync3, filt);
  assign start_fall  = filt[`ACC_SYNC_CONV] & ~next_filt[`ACC_SYNC_CONV];
  assign start_rise  = ~filt[`ACC_SYNC_CONV] & next_filt[`ACC_SYNC_CONV];
  assign read_active = ~filt[`ACC_SYNC_CS] & filt[`ACC_SYNC_RDWR];
  // read_end fires on rising read/write select with chip select low, the start of a read
  assign read_end    = ~filt[`ACC_SYNC_CS] & ~filt[`ACC_SYNC_RDWR] & next_filt[`ACC_SYNC_RDWR];
  assign wr_event    = filt[`ACC_SYNC_WRTOG] ^ next_filt[`ACC_SYNC_WRTOG];
  // upper five bits all zero selects the address register
  assign wr_is_addr  = (link.wr_byte[`ACC_ADDR_SEL_MSB:`ACC_ADDR_SEL_LSB] == 5'h00);
  assign conv_done   = (state == ACC_ST_CONVERT) && (conv_cnt == 9'h001);
  assign temp_over   = (adc_data_in[`ACC_RESULT_W-1:`ACC_TEMP_CMP_LSB] > overtemp_threshold_reg);
  assign temp_done   = conv_done && (conv_chan == `ACC_CHAN_TEMP);

  // conversion sequencer on the internal clock
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state     <= ACC_ST_TRACK;
      conv_cnt  <= 9'h000;
      conv_chan <= `ACC_CHAN_RESET;
    end
    else
    begin
      unique case (state)
        ACC_ST_TRACK:
        begin
          if (start_fall)
          begin
            state     <= ACC_ST_CONVERT;
            conv_cnt  <= `ACC_CONV_CNT_W'(`ACC_CONV_CYCLES);
            conv_chan <= analog_inputs_sel_out;
          end
        end
        ACC_ST_CONVERT:
        begin
          conv_cnt <= conv_cnt - 9'h001;
          if (conv_done)
          begin
            state <= ACC_ST_TRACK;
          end
        end
      endcase
    end
  end

  // hold from start edge until the conversion ends
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hold_out <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      hold_out <= (state == ACC_ST_TRACK) ? start_fall : ~conv_done;
      busy_out <= (state == ACC_ST_TRACK) ? start_fall : ~conv_done;
    end
  end

  // start level checked at the end; any start edge after the end cycle wakes the converter
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      power_down_out <= 1'b0;
    end
    else if (conv_done)
    begin
      power_down_out <= ~filt[`ACC_SYNC_CONV];
    end
    else if (start_rise || start_fall)
    begin
      power_down_out <= 1'b0;
    end
  end

  // result frozen while a read shifts it out, so the serial side sees a stable word
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      latest_result <= 10'h000;
      result_word   <= 10'h000;
    end
    else
    begin
      if (conv_done)
      begin
        latest_result <= adc_data_in;
      end
      if (!read_active)
      begin
        result_word <= latest_result;
      end
    end
  end

  assign link.result_word = result_word;

  // alert low on a temperature result above threshold; set wins over the read clear
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      overtemp_alert_n_out <= 1'b1;
    end
    else if (temp_done)
    begin
      overtemp_alert_n_out <= ~temp_over;
    end
    // rising read/write select at the start of a read releases the alert
    else if (read_end)
    begin
      overtemp_alert_n_out <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      analog_inputs_sel_out  <= `ACC_CHAN_RESET;
      overtemp_threshold_reg <= `ACC_THRESH_RESET;
    end
    else if (wr_event)
    begin
      // channel routing follows the address register
      if (wr_is_addr)
      begin
        analog_inputs_sel_out <= link.wr_byte[`ACC_CHAN_W-1:0];
      end
      else
      begin
        overtemp_threshold_reg <= link.wr_byte;
      end
    end
  end

  // enable drops on read/write fall or chip select rise; shared pin
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sdata_oe_out <= 1'b0;
    end
    else
    begin
      sdata_oe_out <= ~next_filt[`ACC_SYNC_CS] & next_filt[`ACC_SYNC_RDWR];
    end
  end

  // falling-edge data flop drives the pin directly
  assign sdata_out = link.sdata;

endmodule : acc_conv_ctrl

// ---- rtl/acc_map.svh ----
// offsets-free map: field positions, reset values and timing counts of the converter control
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_CLK_PERIOD_NS   25
`define ACC_CONV_TIME_NS    9000
`define ACC_CONV_CYCLES     ((`ACC_CONV_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_CONV_CNT_W      9
`define ACC_RESULT_W        10
`define ACC_BYTE_W          8
`define ACC_CHAN_W          3
`define ACC_RD_BITS         4'ha
`define ACC_WR_LAST_BIT     3'h7
`define ACC_CHAN_TEMP       3'h0
`define ACC_CHAN_BANDGAP    3'h7
`define ACC_CHAN_RESET      3'h0
`define ACC_THRESH_RESET    8'h99
`define ACC_ADDR_SEL_MSB    7
`define ACC_ADDR_SEL_LSB    3
`define ACC_TEMP_CMP_LSB    2
`define ACC_SYNC_W          4
`define ACC_SYNC_CONV       0
`define ACC_SYNC_CS         1
`define ACC_SYNC_RDWR       2
`define ACC_SYNC_WRTOG      3

`endif

// ---- rtl/acc_pkg.sv ----
// types shared by the converter control and its serial port
package acc_pkg;

  typedef enum logic { ACC_ST_TRACK, ACC_ST_CONVERT } acc_state_t;
  typedef logic [9:0] acc_result_t;
  typedef logic [7:0] acc_byte_t;
  typedef logic [2:0] acc_chan_t;

endpackage : acc_pkg

// ---- rtl/acc_link_if.sv ----
// crossing signals between the serial-clock side and the converter side
`timescale 1ns/1ps
interface acc_link_if;
  import acc_pkg::*;

  acc_byte_t   wr_byte;
  logic        wr_toggle;
  acc_result_t result_word;
  logic        sdata;

  modport ser
  (
    output wr_byte,
    output wr_toggle,
    output sdata,
    input  result_word
  );

  modport ctl
  (
    input  wr_byte,
    input  wr_toggle,
    input  sdata,
    output result_word
  );
endinterface : acc_link_if

// ---- rtl/acc_serial.sv ----
// serial port shift logic, clocked by the host serial clock
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_serial
(
  // serial link
  input  wire logic sclk_in,
  input  wire logic reset_n_in,
  input  wire logic cs_n_in,
  input  wire logic rd_wr_in,
  input  wire logic sdata_in,
  // converter side
  acc_link_if.ser   link
);
  import acc_pkg::*;

  logic       wr_arm_n;
  logic       rd_arm_n;
  logic [2:0] wr_cnt;
  logic [6:0] wr_shift;
  logic [3:0] rd_cnt;
  logic [9:0] rd_shift;
  logic       wr_last;

  // frame qualifiers act as async clears, since sclk stands still between frames
  assign wr_arm_n = reset_n_in & ~cs_n_in & ~rd_wr_in;
  assign rd_arm_n = reset_n_in & ~cs_n_in & rd_wr_in;
  assign wr_last  = (wr_cnt == `ACC_WR_LAST_BIT);

  always_ff @(posedge sclk_in or negedge wr_arm_n)
  begin
    if (!wr_arm_n)
    begin
      wr_cnt   <= 3'h0;
      wr_shift <= 7'h00;
    end
    else
    begin
      wr_cnt   <= wr_cnt + 3'h1;
      wr_shift <= {wr_shift[5:0], sdata_in};
    end
  end

  // byte complete at eighth rising edge, msb first
  always_ff @(posedge sclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      link.wr_byte   <= 8'h00;
      link.wr_toggle <= 1'b0;
    end
    else if (wr_arm_n && wr_last)
    begin
      link.wr_byte   <= {wr_shift, sdata_in};
      link.wr_toggle <= ~link.wr_toggle;
    end
  end

  // result msb first on falling edges, zeros after bit 0
  always_ff @(negedge sclk_in or negedge rd_arm_n)
  begin
    if (!rd_arm_n)
    begin
      rd_cnt     <= 4'h0;
      rd_shift   <= 10'h000;
      link.sdata <= 1'b0;
    end
    else if (rd_cnt == 4'h0)
    begin
      rd_cnt     <= 4'h1;
      rd_shift   <= {link.result_word[8:0], 1'b0};
      link.sdata <= link.result_word[9];
    end
    else
    begin
      rd_cnt     <= (rd_cnt == `ACC_RD_BITS) ? rd_cnt : rd_cnt + 4'h1;
      rd_shift   <= {rd_shift[8:0], 1'b0};
      link.sdata <= rd_shift[9];
    end
  end
endmodule : acc_serial

// ---- testbench/acc_conv_ctrl_properties.sv ----
// concurrent checks on the converter control top ports
`timescale 1ns/1ps
module acc_props
(
  // clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_n_in,
  // serial link
  input  wire logic                 sclk_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 rd_wr_in,
  input  wire logic                 sdata_in,
  input  wire logic                 sdata_out,
  input  wire logic                 sdata_oe_out,
  // conversion
  input  wire logic                 conversion_start_n_in,
  input  wire acc_pkg::acc_result_t adc_data_in,
  input  wire acc_pkg::acc_chan_t   analog_inputs_sel_out,
  input  wire logic                 hold_out,
  input  wire logic                 busy_out,
  input  wire logic                 power_down_out,
  input  wire logic                 overtemp_alert_n_out
);
  import acc_pkg::*;
  logic [8:0] hold_cnt;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // hold length counted here, too long for a repetition
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      hold_cnt <= 9'h0;
    else
      hold_cnt <= hold_out ? hold_cnt + 9'h1 : 9'h0;
  sequence s_start_fall;
    $fell(conversion_start_n_in) && !busy_out;
  endsequence
  sequence s_read_end;
    $rose(rd_wr_in) && !cs_n_in && !busy_out;
  endsequence
  a_hold_busy_same: assert property (hold_out == busy_out) else $error("hold and busy differ");
  a_start_takes_hold: assert property (s_start_fall |-> ##[1:8] hold_out) else $error("no hold after start");
  a_conv_length: assert property ($fell(hold_out) |-> hold_cnt == 9'h168) else $error("bad hold length");
  a_pd_at_end: assert property ($fell(busy_out) && $past(conversion_start_n_in, 8) == conversion_start_n_in
    |-> power_down_out == !conversion_start_n_in) else $error("power down wrong at end");
  a_pd_wakes: assert property (power_down_out && !$stable(conversion_start_n_in) |-> ##[1:8] !power_down_out)
    else $error("power down not left");
  a_alert_cause: assert property ($fell(overtemp_alert_n_out) |-> ($past(busy_out) || $past(busy_out, 2))
    && analog_inputs_sel_out == 3'h0) else $error("alert without sensor result");
  a_alert_release: assert property (s_read_end |-> ##[1:8] overtemp_alert_n_out) else $error("alert kept");
  a_oe_release: assert property ($fell(rd_wr_in) || $rose(cs_n_in) |-> ##[1:8] !sdata_oe_out)
    else $error("data pin not released");
  a_oe_idle_off: assert property ((!rd_wr_in)[*8] |-> !sdata_oe_out) else $error("pin driven in write");
endmodule : acc_props
bind acc_conv_ctrl acc_props u_props (.ref_clk_in, .reset_n_in, .sclk_in, .cs_n_in, .rd_wr_in, .sdata_in,
  .sdata_out, .sdata_oe_out, .conversion_start_n_in, .adc_data_in, .analog_inputs_sel_out, .hold_out,
  .busy_out, .power_down_out, .overtemp_alert_n_out);

// ---- testbench/acc_host_model.sv ----
// host side: serial clock, select, direction and the shared data pin
`timescale 1ns/1ps
module acc_host_model
(
  // pins toward the device
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      rd_wr_out,
  output logic      sdata_out,
  // device drive of the data pin
  input  wire logic sdata_in,
  input  wire logic sdata_oe_in
);
  import acc_pkg::*;
  logic drv;
  // one wire, device wins while enabled
  assign sdata_out = sdata_oe_in ? sdata_in : drv;
  initial
  begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    rd_wr_out = 1'b0;
    drv = 1'b1;
  end
  // select and direction first, eight clocks msb first
  task automatic write_byte(input acc_byte_t b);
    cs_n_out = 1'b0;
    rd_wr_out = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      // presented while low, taken on the rise
      drv = b[i];
      #80;
      sclk_out = 1'b1;
      #80;
    end
    // inverted so a stale bit never looks valid
    drv = ~b[0];
    cs_n_out = 1'b1;
    #300;
  endtask : write_byte
  // read frame, ended by direction or select
  task automatic read_word(output acc_result_t w, input logic by_cs);
    // select settles first, so the direction rise is seen with select low
    cs_n_out = 1'b0;
    #200;
    rd_wr_out = 1'b1;
    #250;
    for (int i = 9; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      #80;
      sclk_out = 1'b1;
      w[i] = sdata_out;
      #80;
    end
    if (by_cs)
      cs_n_out = 1'b1;
    else
      rd_wr_out = 1'b0;
    #250;
    cs_n_out = 1'b1;
    rd_wr_out = 1'b0;
    #200;
  endtask : read_word
endmodule : acc_host_model

// ---- testbench/acc_conv_ctrl_tb_top.sv ----
// self-checking bench for the converter control
`timescale 1ns/1ps
module acc_conv_ctrl_tb_top;
  import acc_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        start_n = 1'b1;
  acc_result_t adc_data = 10'h0;
  logic        sclk, cs_n, rd_wr, sdata, sdo, oe, hold, busy, pd, alert_n;
  acc_chan_t   sel;
  acc_result_t word;
  acc_chan_t   codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  acc_conv_ctrl u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .rd_wr_in(rd_wr), .sdata_in(sdata), .sdata_out(sdo), .sdata_oe_out(oe), .conversion_start_n_in(start_n),
    .adc_data_in(adc_data), .analog_inputs_sel_out(sel), .hold_out(hold), .busy_out(busy),
    .power_down_out(pd), .overtemp_alert_n_out(alert_n));
  acc_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .rd_wr_out(rd_wr), .sdata_out(sdata),
    .sdata_in(sdo), .sdata_oe_in(oe));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic conv(input logic end_low, input acc_result_t d);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    adc_data = d;
    start_n = 1'b0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check("hold", 10'h1, {9'h0, hold});
    repeat (20) @(negedge ref_clk_in);
    // a rise mid-conversion must be ignored
    start_n = ~end_low;
    while (busy !== 1'b0 && n < 500)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check("hold", 10'h0, {9'h0, hold});
    check("power_down", {9'h0, end_low}, {9'h0, pd});
    // start level kept past the end so the end-of-conversion check sees it
    repeat (2) @(negedge ref_clk_in);
    start_n = 1'b1;
    repeat (10) @(negedge ref_clk_in);
  endtask : conv
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    check("sel", 10'h0, {7'h0, sel});
    check("alert_n", 10'h1, {9'h0, alert_n});
    foreach (codes[k])
    begin
      u_host.write_byte({5'h0, codes[k]});
      check("sel", {7'h0, codes[k]}, {7'h0, sel});
    end
    conv(1'b1, 10'h3fc);
    check("alert_n", 10'h0, {9'h0, alert_n});
    check("power_down", 10'h0, {9'h0, pd});
    u_host.read_word(word, 1'b0);
    check("result", 10'h3fc, word);
    check("alert_n", 10'h1, {9'h0, alert_n});
    check("oe", 10'h0, {9'h0, oe});
    u_host.write_byte(8'hc8);
    check("sel", 10'h0, {7'h0, sel});
    conv(1'b0, 10'h320);
    check("alert_n", 10'h1, {9'h0, alert_n});
    conv(1'b0, 10'h327);
    check("alert_n", 10'h0, {9'h0, alert_n});
    u_host.read_word(word, 1'b1);
    check("result", 10'h327, word);
    check("oe", 10'h0, {9'h0, oe});
    u_host.write_byte(8'h01);
    conv(1'b0, 10'h3ff);
    check("alert_n", 10'h1, {9'h0, alert_n});
    check("sel", 10'h1, {7'h0, sel});
    give_verdict();
  end
endmodule : acc_conv_ctrl_tb_top
